// ===== rtl/shift_flag_pkg.sv
// shared constants, opcodes and carriers of the shift and flag unit
package shift_flag_pkg;

    localparam int unsigned DATA_W    = 8;
    localparam int unsigned NUM_WREGS = 4;

    // register map, byte addresses of aligned words
    localparam logic [7:0] STATUS_OFF = 8'h00;
    localparam logic [7:0] OP_OFF     = 8'h04;
    localparam logic [7:0] RESULT_OFF = 8'h08;
    localparam logic [7:0] COUNT_OFF  = 8'h0C;
    localparam logic [7:0] WREG_BASE  = 8'h10;
    localparam logic [7:0] WREG_LAST  = 8'h1C;

    // status register bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_T = 3'h6;

    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [7:0]  WREG_RST   = 8'h00;
    localparam logic [10:0] OP_RST     = 11'h000;
    localparam logic [15:0] COUNT_RST  = 16'h0000;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef enum logic [3:0] {
        logical_right_shift_op = 4'h0,
        rotate_left_carry_op   = 4'h1,
        rotate_right_carry_op  = 4'h2,
        arith_right_shift_op   = 4'h3,
        nibble_swap_op         = 4'h4,
        flag_set_op            = 4'h5,
        flag_clear_op          = 4'h6,
        bit_to_transfer_op     = 4'h7,
        transfer_to_bit_op     = 4'h8,
        carry_set_op           = 4'h9,
        carry_clear_op         = 4'hA,
        negative_set_op        = 4'hB,
        negative_clear_op      = 4'hC,
        zero_flag_set_op       = 4'hD,
        zero_flag_clear_op     = 4'hE,
        no_op                  = 4'hF
    } op_code_t;

    // operation word as written to the op register, bits 10:0
    typedef struct packed {
        logic [1:0] src;
        logic [1:0] dst;
        logic [2:0] bit_idx;
        op_code_t   code;
    } op_word_t;

    // value and status produced by one operation
    typedef struct packed {
        logic [7:0] value;
        logic [7:0] status;
        logic       writes_dst;
    } alu_out_t;

    // zero, carry, negative and overflow after a shift or rotate
    function automatic logic [7:0] shift_flags(input logic [7:0] st,
                                               input logic [7:0] res,
                                               input logic       cy);
        logic [7:0] s;
        s = st;
        s[FLAG_C] = cy;
        s[FLAG_Z] = (res == 8'h00);
        s[FLAG_N] = res[7];
        s[FLAG_V] = res[7] ^ cy;
        return s;
    endfunction

    function automatic logic [7:0] one_hot8(input logic [2:0] idx);
        return 8'(8'h01 << idx);
    endfunction

endpackage

// ===== rtl/shift_unit.sv
// shifts, rotates through carry and nibble exchange
module shift_unit (
    input  wire shift_flag_pkg::op_code_t code,
    input  wire logic [7:0]               operand,
    input  wire logic [7:0]               status_in,
    output shift_flag_pkg::alu_out_t      out
);
    logic [7:0] res;
    logic       cy;

    always_comb begin
        res = operand;
        cy  = status_in[shift_flag_pkg::FLAG_C];
        out = '0;
        case (code)
            shift_flag_pkg::logical_right_shift_op: begin
                res = {1'b0, operand[7:1]};
                cy  = operand[0];
            end
            shift_flag_pkg::rotate_left_carry_op: begin
                res = {operand[6:0], status_in[shift_flag_pkg::FLAG_C]};
                cy  = operand[7];
            end
            shift_flag_pkg::rotate_right_carry_op: begin
                res = {status_in[shift_flag_pkg::FLAG_C], operand[7:1]};
                cy  = operand[0];
            end
            shift_flag_pkg::arith_right_shift_op: begin
                res = {operand[7], operand[7:1]};
                cy  = operand[0];
            end
            shift_flag_pkg::nibble_swap_op: begin
                res = {operand[3:0], operand[7:4]};
            end
            default: begin
                res = operand;
            end
        endcase
        out.value      = res;
        out.writes_dst = 1'b1;
        // swap leaves every flag alone
        if (code == shift_flag_pkg::nibble_swap_op) begin
            out.status = status_in;
        end else begin
            out.status = shift_flag_pkg::shift_flags(status_in, res, cy);
        end
    end
endmodule

// ===== rtl/bit_unit.sv
// single status bit set and clear, transfer flag store and load
module bit_unit (
    input  wire shift_flag_pkg::op_code_t code,
    input  wire logic [2:0]               bit_idx,
    input  wire logic [7:0]               dst_val,
    input  wire logic [7:0]               src_val,
    input  wire logic [7:0]               status_in,
    output shift_flag_pkg::alu_out_t      out
);
    logic [2:0] idx;
    logic       set_bit;
    logic       touch;

    always_comb begin
        idx     = bit_idx;
        set_bit = 1'b0;
        touch   = 1'b1;
        out     = '0;
        out.value = dst_val;
        case (code)
            shift_flag_pkg::flag_set_op:        set_bit = 1'b1;
            shift_flag_pkg::flag_clear_op:      set_bit = 1'b0;
            shift_flag_pkg::carry_set_op: begin
                idx = shift_flag_pkg::FLAG_C;
                set_bit = 1'b1;
            end
            shift_flag_pkg::carry_clear_op:     idx = shift_flag_pkg::FLAG_C;
            shift_flag_pkg::negative_set_op: begin
                idx = shift_flag_pkg::FLAG_N;
                set_bit = 1'b1;
            end
            shift_flag_pkg::negative_clear_op:  idx = shift_flag_pkg::FLAG_N;
            shift_flag_pkg::zero_flag_set_op: begin
                idx = shift_flag_pkg::FLAG_Z;
                set_bit = 1'b1;
            end
            shift_flag_pkg::zero_flag_clear_op: idx = shift_flag_pkg::FLAG_Z;
            shift_flag_pkg::bit_to_transfer_op: begin
                idx = shift_flag_pkg::FLAG_T;
                set_bit = src_val[bit_idx];
            end
            default: touch = 1'b0;
        endcase
        out.status = status_in;
        if (touch) begin
            out.status[idx] = set_bit;
        end
        out.writes_dst = (code == shift_flag_pkg::transfer_to_bit_op);
        if (out.writes_dst) begin
            out.value[bit_idx] = status_in[shift_flag_pkg::FLAG_T];
        end
    end
endmodule

// ===== rtl/shift_flag_unit.sv
// ahb-lite shell with working registers, status register and execution
// What this block does
// - rotate left through carry: old carry into bit 0, bit 7 to carry
// - rotate right through carry: old carry into bit 7, bit 0 to carry
// - arithmetic right shift moves bits down, bit 7 keeps its value
// - rotates and shifts update zero, carry, negative and overflow flags
// - nibble swap exchanges register halves and leaves all flags unchanged
// - flag set or clear forces only the indexed status bit
// - bit store copies selected source bit into the transfer flag only
// - bit load copies transfer flag into selected destination bit only
// - carry set and clear write only the carry flag
// - negative and zero set or clear write only their own flag
module shift_flag_unit #(
    parameter int unsigned NUM_WREGS = shift_flag_pkg::NUM_WREGS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    localparam logic [7:0] N_WREGS8 = 8'(NUM_WREGS);

    logic [7:0]  wreg_q [NUM_WREGS];
    logic [7:0]  status_q;
    logic [10:0] op_q;
    logic [7:0]  result_q;
    logic [15:0] count_q;
    logic [31:0] hrdata_q;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic        accept;
    logic        rd_req;

    shift_flag_pkg::op_word_t op_in;
    shift_flag_pkg::alu_out_t sh_out;
    shift_flag_pkg::alu_out_t bt_out;
    shift_flag_pkg::alu_out_t alu;
    logic                     exec;
    logic                     is_shift;
    logic [7:0]               dst_val;
    logic [7:0]               src_val;

    // true when an address selects one of the working registers
    function automatic logic is_wreg(input logic [7:0] a);
        return (a >= shift_flag_pkg::WREG_BASE) &&
               (a <= shift_flag_pkg::WREG_LAST) && (a[1:0] == 2'h0) &&
               (((a - shift_flag_pkg::WREG_BASE) >> 2) < N_WREGS8);
    endfunction

    function automatic logic [1:0] wreg_idx(input logic [7:0] a);
        logic [7:0] d;
        d = 8'(a - shift_flag_pkg::WREG_BASE);
        return d[3:2];
    endfunction

    // bus side: zero wait states except one stall for a read that follows
    // a write, so the read never sees the value from before the write
    assign rd_req    = hsel && htrans[1] && !hwrite;
    assign hreadyout = !(wr_pend_q && rd_req);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign accept    = hsel && htrans[1] && hready && hreadyout;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= accept && hwrite;
            if (accept) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (accept && !hwrite) begin
            hrdata_q <= 32'h00000000;
            case (haddr[7:0])
                shift_flag_pkg::STATUS_OFF: hrdata_q[7:0]  <= status_q;
                shift_flag_pkg::OP_OFF:     hrdata_q[10:0] <= op_q;
                shift_flag_pkg::RESULT_OFF: hrdata_q[7:0]  <= result_q;
                shift_flag_pkg::COUNT_OFF:  hrdata_q[15:0] <= count_q;
                default: begin
                    if (is_wreg(haddr[7:0])) begin
                        hrdata_q[7:0] <= wreg_q[wreg_idx(haddr[7:0])];
                    end
                end
            endcase
        end
    end

    // a write to the op register runs the operation in that data phase
    assign op_in   = shift_flag_pkg::op_word_t'(hwdata[10:0]);
    assign exec    = wr_pend_q && (wr_addr_q == shift_flag_pkg::OP_OFF) &&
                     (op_in.code != shift_flag_pkg::no_op);
    assign dst_val = wreg_q[op_in.dst];
    assign src_val = wreg_q[op_in.src];
    assign is_shift = (op_in.code <= shift_flag_pkg::nibble_swap_op);

    shift_unit u_shift (
        .code      (op_in.code),
        .operand   (dst_val),
        .status_in (status_q),
        .out       (sh_out)
    );

    bit_unit u_bit (
        .code      (op_in.code),
        .bit_idx   (op_in.bit_idx),
        .dst_val   (dst_val),
        .src_val   (src_val),
        .status_in (status_q),
        .out       (bt_out)
    );

    assign alu = is_shift ? sh_out : bt_out;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= shift_flag_pkg::STATUS_RST;
        end else if (exec) begin
            status_q <= alu.status;
        end else if (wr_pend_q &&
                     wr_addr_q == shift_flag_pkg::STATUS_OFF) begin
            status_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_WREGS; i++) begin
                wreg_q[i] <= shift_flag_pkg::WREG_RST;
            end
        end else if (exec) begin
            if (alu.writes_dst) begin
                wreg_q[op_in.dst] <= alu.value;
            end
        end else if (wr_pend_q && is_wreg(wr_addr_q)) begin
            wreg_q[wreg_idx(wr_addr_q)] <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_q     <= shift_flag_pkg::OP_RST;
            result_q <= 8'h00;
            count_q  <= shift_flag_pkg::COUNT_RST;
        end else if (exec) begin
            op_q     <= hwdata[10:0];
            result_q <= alu.value;
            count_q  <= 16'(count_q + 16'h0001);
        end
    end

    // checking aids: operands as they stood when the operation ran
    shift_flag_pkg::op_word_t chk_op_q;
    logic [7:0]               chk_dst_q;
    logic [7:0]               chk_src_q;
    logic [7:0]               chk_st_q;
    logic                     chk_exec_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chk_exec_q <= 1'b0;
            chk_op_q   <= shift_flag_pkg::op_word_t'(shift_flag_pkg::OP_RST);
            chk_dst_q  <= 8'h00;
            chk_src_q  <= 8'h00;
            chk_st_q   <= 8'h00;
        end else begin
            chk_exec_q <= exec;
            if (exec) begin
                chk_op_q  <= op_in;
                chk_dst_q <= dst_val;
                chk_src_q <= src_val;
                chk_st_q  <= status_q;
            end
        end
    end

    rotate_left_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chk_exec_q && chk_op_q.code == shift_flag_pkg::rotate_left_carry_op
        |-> result_q == {chk_dst_q[6:0], chk_st_q[0]} &&
            status_q[0] == chk_dst_q[7])
        else $error("rotate left through carry wrong");

    rotate_right_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chk_exec_q && chk_op_q.code == shift_flag_pkg::rotate_right_carry_op
        |-> result_q == {chk_st_q[0], chk_dst_q[7:1]} &&
            status_q[0] == chk_dst_q[0])
        else $error("rotate right through carry wrong");

    arith_shift_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chk_exec_q && chk_op_q.code == shift_flag_pkg::arith_right_shift_op
        |-> result_q == {chk_dst_q[7], chk_dst_q[7:1]})
        else $error("arithmetic shift lost the sign");

    shift_flags_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chk_exec_q && chk_op_q.code < shift_flag_pkg::nibble_swap_op
        |-> status_q[1] == (result_q == 8'h00) &&
            status_q[2] == result_q[7] &&
            status_q[3] == (status_q[2] ^ status_q[0]) &&
            status_q[7:4] == chk_st_q[7:4])
        else $error("shift flags wrong");

    swap_keeps_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chk_exec_q && chk_op_q.code == shift_flag_pkg::nibble_swap_op
        |-> result_q == {chk_dst_q[3:0], chk_dst_q[7:4]} &&
            $stable(status_q))
        else $error("nibble swap wrong or flags moved");

    single_flag_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chk_exec_q && (chk_op_q.code == shift_flag_pkg::flag_set_op ||
                       chk_op_q.code == shift_flag_pkg::flag_clear_op)
        |-> status_q == ((chk_op_q.code == shift_flag_pkg::flag_set_op) ?
            (chk_st_q | shift_flag_pkg::one_hot8(chk_op_q.bit_idx)) :
            (chk_st_q & ~shift_flag_pkg::one_hot8(chk_op_q.bit_idx))))
        else $error("flag set or clear touched other bits");

    bit_store_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chk_exec_q && chk_op_q.code == shift_flag_pkg::bit_to_transfer_op
        |-> status_q[6] == chk_src_q[chk_op_q.bit_idx] &&
            status_q[5:0] == chk_st_q[5:0] &&
            status_q[7] == chk_st_q[7])
        else $error("bit store to transfer flag wrong");

    bit_load_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chk_exec_q && chk_op_q.code == shift_flag_pkg::transfer_to_bit_op
        |-> wreg_q[chk_op_q.dst][chk_op_q.bit_idx] == chk_st_q[6] &&
            (wreg_q[chk_op_q.dst] |
             shift_flag_pkg::one_hot8(chk_op_q.bit_idx)) ==
            (chk_dst_q | shift_flag_pkg::one_hot8(chk_op_q.bit_idx)) &&
            status_q == chk_st_q)
        else $error("bit load from transfer flag wrong");

    carry_op_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chk_exec_q && (chk_op_q.code == shift_flag_pkg::carry_set_op ||
                       chk_op_q.code == shift_flag_pkg::carry_clear_op)
        |-> status_q == {chk_st_q[7:1],
            chk_op_q.code == shift_flag_pkg::carry_set_op})
        else $error("carry set or clear wrong");

    nz_op_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chk_exec_q && chk_op_q.code >= shift_flag_pkg::negative_set_op &&
        chk_op_q.code <= shift_flag_pkg::zero_flag_clear_op
        |-> status_q[7:3] == chk_st_q[7:3] && status_q[0] == chk_st_q[0]
            && (chk_op_q.code > shift_flag_pkg::negative_clear_op ?
                status_q[2] == chk_st_q[2] :
                status_q[1] == chk_st_q[1]))
        else $error("negative or zero op touched another flag");

    logical_shift_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chk_exec_q && chk_op_q.code == shift_flag_pkg::logical_right_shift_op
        |-> result_q == {1'b0, chk_dst_q[7:1]} &&
            status_q[0] == chk_dst_q[0])
        else $error("logical right shift wrong");

    one_cycle_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        exec && (is_shift ||
                 op_in.code == shift_flag_pkg::transfer_to_bit_op)
        |=> wreg_q[chk_op_q.dst] == result_q &&
            count_q == 16'($past(count_q) + 16'h0001))
        else $error("operation did not finish in one cycle");

    // a master that never overlaps phases leaves this stall check idle
    bus_okay_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_q && rd_req |-> !hreadyout ##1 hreadyout)
        else $error("read after write stall is not one cycle");

    count_hold_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !exec |=> $stable(count_q) && $stable(result_q) && $stable(op_q))
        else $error("count or result moved with no operation");

    status_hold_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !exec && !(wr_pend_q && wr_addr_q == shift_flag_pkg::STATUS_OFF)
        |=> $stable(status_q))
        else $error("status moved with no cause");

    nop_quiet_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_q && wr_addr_q == shift_flag_pkg::OP_OFF &&
        op_in.code == shift_flag_pkg::no_op |=> $stable(wreg_q[0]))
        else $error("no-op changed a register");

    status_write_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_q && wr_addr_q == shift_flag_pkg::STATUS_OFF
        |=> {24'h000000, status_q} == ($past(hwdata) & 32'h000000FF))
        else $error("status write lost");

    wreg_write_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_q && is_wreg(wr_addr_q)
        |=> {24'h000000, wreg_q[wreg_idx($past(wr_addr_q))]} ==
            ($past(hwdata) & 32'h000000FF))
        else $error("register write lost");

    status_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        accept && !hwrite && haddr[7:0] == shift_flag_pkg::STATUS_OFF
        |=> hrdata == {24'h000000, $past(status_q)})
        else $error("status read data wrong");

    count_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        accept && !hwrite && haddr[7:0] == shift_flag_pkg::COUNT_OFF
        |=> hrdata == {16'h0000, $past(count_q)})
        else $error("count read data wrong");

    wreg_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        accept && !hwrite && haddr[7:0] == shift_flag_pkg::WREG_BASE
        |=> hrdata == {24'h000000, $past(wreg_q[0])})
        else $error("register read data wrong");

    unmapped_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        accept && !hwrite && haddr[7:0] > shift_flag_pkg::WREG_LAST
        |=> hrdata == 32'h00000000)
        else $error("unmapped read not zero");

endmodule

// ===== verif/shift_flag_unit_tb.sv
// self-checking bench for the shift and flag unit over ahb-lite
module shift_flag_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire logic   hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    int          miscompares;
    int          checks_done;
    logic [7:0]  st_m;
    logic [7:0]  wr_m [4];
    logic [7:0]  res_m;
    logic [15:0] cnt_m;
    logic [10:0] op_m;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    shift_flag_unit #(.NUM_WREGS(4)) dut_u (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp)
    );

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // ready and read data are sampled half a cycle ahead of the edge,
    // where they already stand as that edge will see them
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        logic rdy;
        int   n;
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        htrans <= shift_flag_pkg::HTRANS_NONSEQ;
        n   = 0;
        rdy = 1'b0;
        rd  = '0;
        while (rdy !== 1'b1 && n < 20) begin
            @(negedge hclk);
            rdy = hreadyout;
            @(posedge hclk);
            n++;
        end
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        rdy = 1'b0;
        while (rdy !== 1'b1 && n < 20) begin
            @(negedge hclk);
            rdy = hreadyout;
            rd  = hrdata;
            @(posedge hclk);
            n++;
        end
        check({31'h0, hresp}, 32'h0, "response");
        if (n >= 20) begin
            miscompares++;
            $display("FAIL %0t bus wait too long", $time);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                         input string what);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0, rd);
        check(rd, exp, what);
    endtask

    task automatic set_wreg(input logic [1:0] i, input logic [7:0] v);
        wr_m[i] = v;
        wr(8'(shift_flag_pkg::WREG_BASE + {i, 2'b00}), {24'h0, v});
    endtask

    task automatic set_st(input logic [7:0] v);
        st_m = v;
        wr(shift_flag_pkg::STATUS_OFF, {24'h0, v});
    endtask

    task automatic run_op(input logic [3:0] code, input logic [2:0] idx,
                          input logic [1:0] d, input logic [1:0] s);
        logic [7:0]  v;
        logic [7:0]  r;
        logic        c;
        logic [10:0] w;
        w = {s, d, idx, code};
        v = wr_m[d];
        r = v;
        c = st_m[0];
        case (code)
            4'h0: begin r = {1'b0, v[7:1]}; c = v[0]; end
            4'h1: begin r = {v[6:0], st_m[0]}; c = v[7]; end
            4'h2: begin r = {st_m[0], v[7:1]}; c = v[0]; end
            4'h3: begin r = {v[7], v[7:1]}; c = v[0]; end
            4'h4: r = {v[3:0], v[7:4]};
            4'h5: st_m[idx] = 1'b1;
            4'h6: st_m[idx] = 1'b0;
            4'h7: st_m[6] = wr_m[s][idx];
            4'h8: r[idx] = st_m[6];
            4'h9: st_m[0] = 1'b1;
            4'hA: st_m[0] = 1'b0;
            4'hB: st_m[2] = 1'b1;
            4'hC: st_m[2] = 1'b0;
            4'hD: st_m[1] = 1'b1;
            4'hE: st_m[1] = 1'b0;
            default: ;
        endcase
        if (code < 4'h4) begin
            st_m[0] = c;
            st_m[1] = (r == 8'h00);
            st_m[2] = r[7];
            st_m[3] = r[7] ^ c;
        end
        // the no-op leaves every register and the count alone
        if (code != 4'hF) begin
            wr_m[d] = r;
            res_m   = r;
            cnt_m++;
            op_m    = w;
        end
        wr(shift_flag_pkg::OP_OFF, {21'h0, w});
        rdchk(shift_flag_pkg::RESULT_OFF, {24'h0, res_m}, "result");
        rdchk(8'(shift_flag_pkg::WREG_BASE + {d, 2'b00}), {24'h0, wr_m[d]},
              "dst value");
        rdchk(shift_flag_pkg::STATUS_OFF, {24'h0, st_m},
              "status");
        rdchk(shift_flag_pkg::COUNT_OFF, {16'h0, cnt_m}, "count");
        rdchk(shift_flag_pkg::OP_OFF, {21'h0, op_m}, "op word");
    endtask

    task automatic clear_model();
        st_m  = 8'h00;
        res_m = 8'h00;
        cnt_m = 16'h0000;
        op_m  = 11'h000;
        for (int i = 0; i < 4; i++) wr_m[i] = 8'h00;
    endtask

    task automatic preload();
        for (int i = 0; i < 4; i++) set_wreg(2'(i), 8'($urandom));
        set_st(8'($urandom));
    endtask

    initial begin
        #200000;
        miscompares++;
        $display("FAIL %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        logic [7:0] edge_v [5];
        edge_v = '{8'h00, 8'h01, 8'h80, 8'hFF, 8'h7F};
        miscompares = 0;
        checks_done = 0;
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        clear_model();
        void'($urandom(37426));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // reset values, unmapped places read zero
        for (int a = 0; a < 8'h24; a += 4) rdchk(8'(a), 32'h0, "reset");
        rdchk(8'hFC, 32'h0, "unmapped");
        $display("test reset done");
        preload();
        for (int k = 0; k < 16; k++) begin
            run_op(4'(k), 3'($urandom), 2'($urandom), 2'($urandom));
        end
        $display("test every code done");
        // shift boundaries with both carry values
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 10; j++) begin
                set_wreg(2'h1, edge_v[j / 2]);
                set_st({7'($urandom), 1'(j)});
                run_op(4'(k), 3'h0, 2'h1, 2'h0);
            end
        end
        $display("test shift edges done");
        // read-only and unmapped writes are dropped
        wr(shift_flag_pkg::RESULT_OFF, 32'hFFFFFFFF);
        wr(shift_flag_pkg::COUNT_OFF, 32'hFFFFFFFF);
        wr(8'h40, 32'hFFFFFFFF);
        rdchk(shift_flag_pkg::RESULT_OFF, {24'h0, res_m}, "result ro");
        rdchk(shift_flag_pkg::COUNT_OFF, {16'h0, cnt_m}, "count ro");
        rdchk(8'h40, 32'h0, "unmapped write");
        $display("test refusals done");
        for (int k = 0; k < 300; k++) begin
            if ($urandom_range(7, 0) == 0) preload();
            run_op(4'($urandom), 3'($urandom), 2'($urandom), 2'($urandom));
        end
        $display("test random ops done");
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        clear_model();
        rdchk(shift_flag_pkg::STATUS_OFF, 32'h0, "status after reset");
        rdchk(shift_flag_pkg::COUNT_OFF, 32'h0, "count after reset");
        run_op(4'h9, 3'h0, 2'h2, 2'h3);
        $display("test second reset done");
        final_report();
    end
endmodule
